// ---- pkg/card_irq_defs.vh ----
// constants for the card host queue event flag block
`ifndef CARD_IRQ_DEFS_VH
`define CARD_IRQ_DEFS_VH

// register offsets (byte addresses)
`define OFS_SOURCE 12'h000
`define OFS_MASK 12'h004
`define OFS_CLEAR 12'h008
`define OFS_THRESH 12'h038
`define ADDR_W 12

// widths
`define FLAG_N 11
`define MASK_W 19
`define LVL_W 12

// reset values
`define MASK_RST 19'h7FFFF
`define THRESH_RST 12'h000

// threshold register fields
`define THR_RX_LSB 0
`define THR_TX_LSB 16

// flag bit positions
`define FB_BUSY_DONE 10
`define FB_CARD_TX_ERR 9
`define FB_CARD_RX_ERR 8
`define FB_BUS_RX_ERR 7
`define FB_BUS_TX_ERR 6
`define FB_RX_FULL 5
`define FB_RX_THR 4
`define FB_RX_NONEMPTY 3
`define FB_TX_SPACE 2
`define FB_TX_THR 1
`define FB_TX_EMPTY 0

// access size codes
`define SZ_BYTE 2'h0
`define SZ_HALF 2'h1
`define SZ_WORD 2'h2

`endif

// ---- hdl/queue_access_checker.v ----
// byte pointer tracking and error pulse for one bus side of a queue
`timescale 1ns/1ps
`include "card_irq_defs.vh"

module queue_access_checker
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // bus side access to the queue
    input wire acc,
    input wire [1:0] size,
    input wire xrun,
    // one-cycle error pulse
    output reg err_r
);

reg [1:0] ptr_r;
reg [1:0] last_size_r;
reg [1:0] step;
wire misalign;

// bytes moved by one access of the given size
always @*
begin
    case (size)
        `SZ_BYTE: step = 2'h1;
        `SZ_HALF: step = 2'h2;
        default: step = 2'h0; // word wraps the pointer back onto itself
    endcase
end

// width change while the pointer sits off byte zero
assign misalign = acc && (size != last_size_r) && (ptr_r != 2'h0);

// pointer kept even across misaligned accesses so later checks stay honest
always @(posedge clock)
begin
    if (!rst_n)
    begin
        ptr_r <= 2'h0;
        last_size_r <= `SZ_WORD;
        err_r <= 1'b0;
    end
    else
    begin
        if (acc)
        begin
            ptr_r <= ptr_r + step;
            last_size_r <= size;
        end
        err_r <= misalign | xrun;
    end
end

endmodule // queue_access_checker

// ---- hdl/card_host_fifo_irq_flags.v ----
// raw queue and busy event flags with mask, clear and interrupt output
`timescale 1ns/1ps
`include "card_irq_defs.vh"

// Overview of operation
// - set bit 10 when the card leaves its busy condition
// - card side send overrun/misalign sets bit 9, receive underrun/misalign bit 8
// - a width change while the byte pointer is off byte zero is misaligned
// - set bit 5 when the receive queue becomes full
// - set bit 4 when receive byte count rises above the programmed threshold
// - set bit 3 when the receive queue goes from empty to non-empty
// - set bit 2 when the send queue goes from full to having space
// - set bit 1 when send free space rises above the programmed threshold
// - set bit 0 when the send queue becomes empty
// - flags read unmasked from a read-only source register at offset zero
// - per-flag mask, one blocks the interrupt, all mask bits reset to one
// - writing one to a clear register bit clears exactly that flag
module card_host_fifo_irq_flags
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register port, APB signalling
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata_r,
    output reg pready_r,
    output reg pslverr_r,
    // card side status
    input wire card_busy,
    input wire card_tx_overrun,
    input wire card_tx_misalign,
    input wire card_rx_underrun,
    input wire card_rx_misalign,
    // bus side queue accesses
    input wire bus_tx_push,
    input wire [1:0] bus_tx_size,
    input wire bus_tx_overrun,
    input wire bus_rx_pop,
    input wire [1:0] bus_rx_size,
    input wire bus_rx_underrun,
    // queue levels
    input wire rx_full,
    input wire rx_empty,
    input wire [`LVL_W-1:0] rx_level,
    input wire tx_full,
    input wire tx_empty,
    input wire [`LVL_W-1:0] tx_space,
    // interrupt
    output reg irq_r
);

reg [`FLAG_N-1:0] flags_r;
reg [`FLAG_N-1:0] flags_nxt;
reg [`MASK_W-1:0] mask_r;
reg [`LVL_W-1:0] rx_thr_r;
reg [`LVL_W-1:0] tx_thr_r;
reg busy_q_r;
reg rx_full_q_r;
reg rx_empty_q_r;
reg tx_full_q_r;
reg tx_empty_q_r;
reg rx_above_q_r;
reg tx_above_q_r;
reg [`FLAG_N-1:0] set_v;
reg [`FLAG_N-1:0] clr_v;
reg [31:0] rd_data;
reg addr_ok;
wire bus_tx_err;
wire bus_rx_err;
wire rx_above;
wire tx_above;
wire acc_done;
wire wr_done;

// one wait state: pready comes from a flop, so the access ends a cycle later
assign acc_done = psel && penable && pready_r;
assign wr_done = acc_done && pwrite;

// level comparisons against the programmed thresholds
assign rx_above = rx_level > rx_thr_r;
assign tx_above = tx_space > tx_thr_r;

// bus side send queue: pushes from the internal bus
queue_access_checker u_tx_check
(
    .clock(clock),
    .rst_n(rst_n),
    .acc(bus_tx_push),
    .size(bus_tx_size),
    .xrun(bus_tx_overrun),
    .err_r(bus_tx_err)
);

// bus side receive queue: pops from the internal bus
queue_access_checker u_rx_check
(
    .clock(clock),
    .rst_n(rst_n),
    .acc(bus_rx_pop),
    .size(bus_rx_size),
    .xrun(bus_rx_underrun),
    .err_r(bus_rx_err)
);

// event detection: level edges against their previous value; error pulses set their flags directly
always @*
begin
    set_v = {`FLAG_N{1'b0}};
    set_v[`FB_BUSY_DONE] = busy_q_r && !card_busy;
    set_v[`FB_CARD_TX_ERR] = card_tx_overrun | card_tx_misalign;
    set_v[`FB_CARD_RX_ERR] = card_rx_underrun | card_rx_misalign;
    set_v[`FB_BUS_RX_ERR] = bus_rx_err;
    set_v[`FB_BUS_TX_ERR] = bus_tx_err;
    set_v[`FB_RX_FULL] = rx_full && !rx_full_q_r;
    set_v[`FB_RX_THR] = rx_above && !rx_above_q_r;
    set_v[`FB_RX_NONEMPTY] = rx_empty_q_r && !rx_empty;
    set_v[`FB_TX_SPACE] = tx_full_q_r && !tx_full;
    set_v[`FB_TX_THR] = tx_above && !tx_above_q_r;
    set_v[`FB_TX_EMPTY] = tx_empty && !tx_empty_q_r;
end

// clear vector from a completed write to the clear register
always @*
begin
    clr_v = {`FLAG_N{1'b0}};
    if (wr_done && (paddr == `OFS_CLEAR))
    begin
        clr_v = pwdata[`FLAG_N-1:0];
    end
end

// sticky flags: a set in the clearing cycle wins, so no event is lost
always @*
begin
    flags_nxt = (flags_r & ~clr_v) | set_v;
end

// read mux and address decode
always @*
begin
    rd_data = 32'h00000000;
    addr_ok = 1'b1;
    case (paddr)
        `OFS_SOURCE: rd_data[`FLAG_N-1:0] = flags_r;
        `OFS_MASK: rd_data[`MASK_W-1:0] = mask_r;
        `OFS_CLEAR: rd_data = 32'h00000000; // write only, reads zero
        `OFS_THRESH:
        begin
            rd_data[`THR_RX_LSB +: `LVL_W] = rx_thr_r;
            rd_data[`THR_TX_LSB +: `LVL_W] = tx_thr_r;
        end
        default: addr_ok = 1'b0;
    endcase
end

// register port handshake and read data
always @(posedge clock)
begin
    if (!rst_n)
    begin
        pready_r <= 1'b0;
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
    end
    else
    begin
        pready_r <= psel && penable && !pready_r;
        // writes to the source register are refused as an error
        pslverr_r <= psel && penable && !pready_r
            && (!addr_ok || (pwrite && (paddr == `OFS_SOURCE)));
        if (psel && penable && !pready_r && !pwrite)
        begin
            prdata_r <= rd_data;
        end
    end
end

// software registers: mask and thresholds
always @(posedge clock)
begin
    if (!rst_n)
    begin
        mask_r <= `MASK_RST;
        rx_thr_r <= `THRESH_RST;
        tx_thr_r <= `THRESH_RST;
    end
    else if (wr_done)
    begin
        if (paddr == `OFS_MASK)
        begin
            mask_r <= pwdata[`MASK_W-1:0];
        end
        if (paddr == `OFS_THRESH)
        begin
            rx_thr_r <= pwdata[`THR_RX_LSB +: `LVL_W];
            tx_thr_r <= pwdata[`THR_TX_LSB +: `LVL_W];
        end
    end
end

// history of levels; reset values match an idle, empty pair of queues
always @(posedge clock)
begin
    if (!rst_n)
    begin
        busy_q_r <= 1'b0;
        rx_full_q_r <= 1'b0;
        rx_empty_q_r <= 1'b1;
        tx_full_q_r <= 1'b0;
        tx_empty_q_r <= 1'b1;
        rx_above_q_r <= 1'b0;
        tx_above_q_r <= 1'b0;
    end
    else
    begin
        busy_q_r <= card_busy;
        rx_full_q_r <= rx_full;
        rx_empty_q_r <= rx_empty;
        tx_full_q_r <= tx_full;
        tx_empty_q_r <= tx_empty;
        rx_above_q_r <= rx_above;
        tx_above_q_r <= tx_above;
    end
end

// flags and interrupt; irq follows the stored flags one cycle later
always @(posedge clock)
begin
    if (!rst_n)
    begin
        flags_r <= {`FLAG_N{1'b0}};
        irq_r <= 1'b0;
    end
    else
    begin
        flags_r <= flags_nxt;
        irq_r <= |(flags_r & ~mask_r[`FLAG_N-1:0]);
    end
end

endmodule // card_host_fifo_irq_flags

// ---- sim/card_host_fifo_irq_flags_properties.sv ----
// register port and interrupt checker for the queue event flag block
`timescale 1ns/1ps
`include "card_irq_defs.vh"

module fifo_irq_checker
(
    // clock and reset
    input wire clock,
    input wire rst_n,
    // register port
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] prdata_r,
    input wire pready_r,
    input wire pslverr_r,
    // interrupt
    input wire irq_r
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    // decode kept here so a wrong decode in the design shows up
    wire mapped = paddr == `OFS_SOURCE || paddr == `OFS_MASK || paddr == `OFS_CLEAR
        || paddr == `OFS_THRESH;
    wire bad = !mapped || (pwrite && paddr == `OFS_SOURCE);
    wire wr_done = psel && penable && pready_r && pwrite
        && (paddr == `OFS_MASK || paddr == `OFS_CLEAR);
    wire rd_done = psel && pready_r && !pwrite;
    sequence s_take;
        psel && penable && !pready_r;
    endsequence
    property p_ready; s_take |=> pready_r; endproperty
    a_ready: assert property (p_ready) else $error("no ready after access");
    property p_pulse; pready_r |=> !pready_r; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_err; s_take ##0 bad |=> pslverr_r; endproperty
    a_err: assert property (p_err) else $error("refused access not flagged");
    property p_noerr; s_take ##0 !bad |=> !pslverr_r; endproperty
    a_noerr: assert property (p_noerr) else $error("good access flagged");
    property p_errpulse; pslverr_r |-> pready_r; endproperty
    a_errpulse: assert property (p_errpulse) else $error("error without ready");
    property p_hold; !(psel && penable && !pready_r && !pwrite) |=> $stable(prdata_r); endproperty
    a_hold: assert property (p_hold) else $error("read data changed outside a read");
    property p_quiet; $rose(rst_n) |-> !irq_r [*3]; endproperty
    a_quiet: assert property (p_quiet) else $error("irq while mask at reset");
    property p_src_hi; rd_done && paddr == `OFS_SOURCE |-> prdata_r[31:11] == 21'h0; endproperty
    a_src_hi: assert property (p_src_hi) else $error("source upper bits set");
    property p_zero; rd_done && (!mapped || paddr == `OFS_CLEAR) |-> prdata_r == 32'h0; endproperty
    a_zero: assert property (p_zero) else $error("nonzero read of clear or hole");
    property p_fall;
        $fell(irq_r) |-> $past(wr_done) || $past(wr_done, 2) || $past(wr_done, 3);
    endproperty
    a_fall: assert property (p_fall) else $error("irq dropped without software");
endmodule // fifo_irq_checker

bind card_host_fifo_irq_flags fifo_irq_checker u_chk (.*);

// ---- sim/card_model.sv ----
// behavioural card: busy level and card side queue error pulses
`timescale 1ns/1ps

module card_model
(
    // clock
    input wire clock,
    // card side status
    output logic card_busy,
    output logic [3:0] err
);
    initial
    begin
        card_busy = 1'b0;
        err = 4'h0;
    end
    // one-cycle pulse on error line i, changed just after the edge
    task pulse(input int i);
        @(posedge clock);
        #2 err[i] = 1'b1;
        @(posedge clock);
        #2 err[i] = 1'b0;
    endtask
    // busy held for n cycles, a slow card picks a long n
    task busy(input int n);
        @(posedge clock);
        #2 card_busy = 1'b1;
        repeat (n) @(posedge clock);
        #2 card_busy = 1'b0;
    endtask
endmodule // card_model

// ---- sim/test_card_host_fifo_irq_flags.sv ----
// self-checking bench for the queue event flag block
`timescale 1ns/1ps
`include "card_irq_defs.vh"

module test_card_host_fifo_irq_flags;
    logic clock = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000, rx_level = 12'h000, tx_space = 12'h000, rt, tt;
    logic [31:0] pwdata = 32'h0, prdata_r, q;
    logic pready_r, pslverr_r, irq_r, card_busy, e, m;
    logic [3:0] err;
    logic bus_tx_push = 1'b0, bus_rx_pop = 1'b0, bus_rx_underrun = 1'b0, bus_tx_overrun = 1'b0;
    logic [1:0] bus_tx_size = 2'h0, bus_rx_size = 2'h0;
    logic rx_full = 1'b0, rx_empty = 1'b1, tx_full = 1'b0, tx_empty = 1'b1;
    int mismatches = 0, n_checks = 0, n;
    always #12.5 clock = ~clock;
    card_model u_card_model (.clock(clock), .card_busy(card_busy), .err(err));
    card_host_fifo_irq_flags u_card_host_fifo_irq_flags (.card_tx_overrun(err[0]),
        .card_tx_misalign(err[1]), .card_rx_underrun(err[2]), .card_rx_misalign(err[3]), .*);
    task stop_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task step;
        @(posedge clock);
        #2;
    endtask
    // request held until ready is sampled high at an edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic ee);
        step;
        psel = 1'b1; pwrite = w; paddr = a; pwdata = d;
        step;
        penable = 1'b1;
        n = 0;
        do @(posedge clock); while (pready_r !== 1'b1 && n++ < 20);
        // a ready that never comes counts as a mismatch
        chk({31'h0, pready_r}, 32'h1);
        q = prdata_r;
        e = pslverr_r;
        #2 psel = 1'b0;
        penable = 1'b0;
        chk({31'h0, e}, {31'h0, ee});
    endtask
    task rd(input logic [11:0] a, input logic [31:0] exp, input logic ee);
        apb(1'b0, a, 32'h0, ee);
        chk(q, exp);
    endtask
    function logic [31:0] bit_of(input int b);
        return 32'h1 << b;
    endfunction
    initial
    begin
        #(25 * 4000);
        mismatches++;
        stop_test;
    end
    initial
    begin
        void'($urandom(32'h3327));
        repeat (4) @(posedge clock);
        #2 rst_n = 1'b1;
        rd(`OFS_MASK, 32'h0007FFFF, 1'b0);
        apb(1'b1, `OFS_SOURCE, 32'hFFFFFFFF, 1'b1);
        rd(`OFS_SOURCE, 32'h0, 1'b0);
        rd(12'h00C, 32'h0, 1'b1);
        rt = $urandom_range(1, 4000);
        tt = $urandom_range(1, 4000);
        apb(1'b1, `OFS_THRESH, {4'h0, tt, 4'h0, rt}, 1'b0);
        rd(`OFS_THRESH, {4'h0, tt, 4'h0, rt}, 1'b0);
        // aligned width changes on the receive side must stay quiet
        bus_rx_size = `SZ_HALF; bus_rx_pop = 1'b1;
        step; step;
        bus_rx_size = `SZ_WORD;
        step;
        bus_rx_pop = 1'b0;
        rd(`OFS_SOURCE, 32'h0, 1'b0);
        for (int b = 0; b < `FLAG_N; b++)
        begin
            m = $urandom_range(0, 1);
            apb(1'b1, `OFS_MASK, 32'h0007FFFF ^ (m ? 32'h0 : bit_of(b)), 1'b0);
            case (b)
                0: begin tx_empty = 1'b0; step; tx_empty = 1'b1; end
                1: begin tx_space = tt; step; tx_space = tt + 12'h001; end
                2: begin tx_full = 1'b1; step; tx_full = 1'b0; end
                3: begin rx_empty = 1'b0; step; rx_empty = 1'b1; end
                4: begin rx_level = rt; step; rx_level = rt + 12'h001; step; rx_level = 12'h0; end
                5: begin rx_full = 1'b1; step; rx_full = 1'b0; end
                6: if ($urandom_range(0, 1))
                    begin bus_tx_overrun = 1'b1; step; bus_tx_overrun = 1'b0; end
                else
                    begin bus_tx_size = `SZ_BYTE; bus_tx_push = 1'b1; step;
                    bus_tx_size = `SZ_WORD; step; bus_tx_push = 1'b0; end
                7: if ($urandom_range(0, 1))
                    begin bus_rx_underrun = 1'b1; step; bus_rx_underrun = 1'b0; end
                else
                    begin bus_rx_size = `SZ_BYTE; bus_rx_pop = 1'b1; step;
                    bus_rx_size = `SZ_HALF; step; bus_rx_pop = 1'b0; end
                8: u_card_model.pulse($urandom_range(2, 3));
                9: u_card_model.pulse($urandom_range(0, 1));
                default: u_card_model.busy($urandom_range(1, 8));
            endcase
            repeat (4) step;
            rd(`OFS_SOURCE, bit_of(b), 1'b0);
            chk({31'h0, irq_r}, {31'h0, !m});
            apb(1'b1, `OFS_CLEAR, 32'h7FF ^ bit_of(b), 1'b0);
            rd(`OFS_SOURCE, bit_of(b), 1'b0);
            apb(1'b1, `OFS_CLEAR, bit_of(b), 1'b0);
            rd(`OFS_CLEAR, 32'h0, 1'b0);
            rd(`OFS_SOURCE, 32'h0, 1'b0);
            chk({31'h0, irq_r}, 32'h0);
        end
        stop_test;
    end
endmodule // test_card_host_fifo_irq_flags
